// ---- include/kfp_pkg.sv ----
package kfp_pkg;
	// ---------------------------------------------------------------
	// key pin level encoding
	// ---------------------------------------------------------------
	localparam logic [1:0] KFP_LVL_GND = 2'h0;
	localparam logic [1:0] KFP_LVL_RW = 2'h1;
	localparam logic [1:0] KFP_LVL_SV = 2'h2;

	// ---------------------------------------------------------------
	// memory size, counts and reset values
	// ---------------------------------------------------------------
	localparam int KFP_NUM_BYTES = 13;
	localparam int KFP_INIT_PULSES = 1500;
	localparam int KFP_BITS_PER_BYTE = 8;
	localparam logic [3:0] KFP_PTR_RST = 4'h0;
	localparam logic [10:0] KFP_INIT_RST = 11'h000;
	localparam logic [2:0] KFP_BIT_RST = 3'h0;
	localparam logic [7:0] KFP_BYTE_RST = 8'h00;
	localparam logic [7:0] KFP_MEM_RST = 8'h00;

	// programming port state machine
	typedef enum logic [2:0] {
		KFP_ST_INIT = 3'b000,
		KFP_ST_IDLE = 3'b001,
		KFP_ST_WSEQ1 = 3'b010,
		KFP_ST_WSEQ2 = 3'b011,
		KFP_ST_WSEQ3 = 3'b100,
		KFP_ST_RSEQ = 3'b101,
		KFP_ST_WRITE = 3'b110,
		KFP_ST_READ = 3'b111
	} kfp_state_t;
endpackage

// ---- rtl/kfp_prog_port.sv ----
`timescale 1ns/10ps
// How it works
// - 13 bytes reached via four pins only
// - select, strobe, serial clock, serial data out
// - modes entered only through supervoltage levels
// - ordered strobe/select supervoltage sequence enters write
// - write bits latched LSB first per clock
// - byte committed on select drop, tx low
// - both keys grounded leaves write mode
// - select supervoltage pulse alone enters read
// - read byte shifted out MSB first
// - further clocks give following bytes; ground ends
module kfp_prog_port
	import kfp_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// key pins, level decoded: gnd, read/write, supervoltage
	input wire logic [1:0] i_key_select_input,
	input wire logic [1:0] i_key_strobe_input,
	input wire logic i_key_strobe_data,
	// serial clock pin level, rising edges detected here against the previous level
	input wire logic i_clock_input_pin,
	// serial data out
	output logic o_tx
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	kfp_state_t state_r, state_nxt;
	logic [10:0] init_cnt_r, init_cnt_nxt;
	logic [3:0] ptr_r, ptr_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic tx_r, tx_nxt;
	logic [7:0] mem_r [KFP_NUM_BYTES];
	logic mem_we;
	logic clk_q_r, clk_q_nxt;
	logic clk_rise;
	// set by a latched write bit, cleared by the commit
	logic pend_r, pend_nxt;
	logic sel_sv, sel_rw, str_sv, str_rw, both_gnd;

	// level decode; the core cannot sense volts, so the pad logic
	// hands each key over as a two-bit level code
	assign sel_sv = (i_key_select_input == KFP_LVL_SV);
	assign sel_rw = (i_key_select_input == KFP_LVL_RW);
	assign str_sv = (i_key_strobe_input == KFP_LVL_SV);
	assign str_rw = (i_key_strobe_input == KFP_LVL_RW);
	assign both_gnd = (i_key_select_input == KFP_LVL_GND) &&
		(i_key_strobe_input == KFP_LVL_GND);
	assign clk_rise = i_clock_input_pin & ~clk_q_r;
	assign o_tx = tx_r;

	// next pointer, wrapping after the last byte
	function automatic logic [3:0] next_ptr(input logic [3:0] p);
		if (p == 4'(KFP_NUM_BYTES - 1)) begin
			next_ptr = KFP_PTR_RST;
		end else begin
			next_ptr = p + 4'h1;
		end
	endfunction

	// ---------------------------------------------------------------
	// serial clock edge detect
	// ---------------------------------------------------------------
	// previous pin level; resets low like the idle pin, no false rise
	always_comb begin
		clk_q_nxt = i_clock_input_pin;
	end

	// register the previous pin level
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			clk_q_r <= 1'b0;
		end else begin
			clk_q_r <= clk_q_nxt;
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		init_cnt_nxt = init_cnt_r;
		ptr_nxt = ptr_r;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		mem_we = 1'b0;
		pend_nxt = pend_r;
		case (state_r)
			KFP_ST_INIT: begin
				// power-on sequencing counts clock pulses
				if (clk_rise && sel_rw && str_rw) begin
					init_cnt_nxt = init_cnt_r + 11'h001;
					if (init_cnt_r == 11'(KFP_INIT_PULSES - 1)) begin
						state_nxt = KFP_ST_IDLE;
					end
				end
			end
			KFP_ST_IDLE: begin
				ptr_nxt = KFP_PTR_RST;
				bit_nxt = KFP_BIT_RST;
				pend_nxt = 1'b0;
				if (str_sv && !sel_sv) begin
					state_nxt = KFP_ST_WSEQ1;
				end else if (sel_sv && str_rw) begin
					state_nxt = KFP_ST_RSEQ;
				end
			end
			KFP_ST_WSEQ1: begin
				// a level out of order drops back to idle
				if (sel_sv && str_sv) begin
					state_nxt = KFP_ST_WSEQ2;
				end else if (!str_sv) begin
					state_nxt = KFP_ST_IDLE;
				end
			end
			KFP_ST_WSEQ2: begin
				if (sel_sv && str_rw) begin
					state_nxt = KFP_ST_WSEQ3;
				end else if (!sel_sv) begin
					state_nxt = KFP_ST_IDLE;
				end
			end
			KFP_ST_WSEQ3: begin
				if (sel_rw && str_rw) begin
					state_nxt = KFP_ST_WRITE;
					tx_nxt = 1'b1;
				end else if (!sel_sv) begin
					state_nxt = KFP_ST_IDLE;
				end
			end
			KFP_ST_RSEQ: begin
				if (sel_rw) begin
					state_nxt = KFP_ST_READ;
					// byte 0 preloaded, first clock shows its top bit
					shift_nxt = mem_r[KFP_PTR_RST];
				end else if (!sel_sv) begin
					state_nxt = KFP_ST_IDLE;
				end
			end
			KFP_ST_WRITE: begin
				if (both_gnd) begin
					state_nxt = KFP_ST_IDLE;
					tx_nxt = 1'b0;
				end else if (sel_sv) begin
					if (clk_rise) begin
						// lsb first: shift in from the top
						shift_nxt = {i_key_strobe_data, shift_r[7:1]};
						bit_nxt = bit_r + 3'h1;
						tx_nxt = 1'b1;
						pend_nxt = 1'b1;
					end
				end else if (pend_r) begin
					// select back at rw level with bits latched;
					// a zero byte or a partial byte commits as well,
					// a stale shift value left from reading never does
					mem_we = 1'b1;
					ptr_nxt = next_ptr(ptr_r);
					bit_nxt = KFP_BIT_RST;
					shift_nxt = KFP_BYTE_RST;
					tx_nxt = 1'b0;
					pend_nxt = 1'b0;
				end
			end
			KFP_ST_READ: begin
				if (both_gnd) begin
					state_nxt = KFP_ST_IDLE;
					tx_nxt = 1'b0;
				end else if (sel_sv && clk_rise) begin
					// msb first
					tx_nxt = shift_r[7];
					bit_nxt = bit_r + 3'h1;
					// last bit out: load next byte, wrapping after the last
					if (bit_r == 3'(KFP_BITS_PER_BYTE - 1)) begin
						ptr_nxt = next_ptr(ptr_r);
						shift_nxt = mem_r[next_ptr(ptr_r)];
					end else begin
						shift_nxt = {shift_r[6:0], 1'b0};
					end
				end
			end
			default: begin
				state_nxt = KFP_ST_INIT;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state_r <= KFP_ST_INIT;
			init_cnt_r <= KFP_INIT_RST;
			ptr_r <= KFP_PTR_RST;
			bit_r <= KFP_BIT_RST;
			shift_r <= KFP_BYTE_RST;
			tx_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			init_cnt_r <= init_cnt_nxt;
			ptr_r <= ptr_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			pend_r <= pend_nxt;
		end
	end

	// nonvolatile array, keeps contents across reset;
	// bytes never written read back unknown
	always_ff @(posedge i_clk_sys) begin
		if (mem_we) begin
			mem_r[ptr_r] <= shift_r;
		end
	end
endmodule // kfp_prog_port

// ---- testbench/kfp_prog_port_bench.sv ----
`timescale 1ns/10ps
module kfp_prog_port_bench;
	import kfp_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	wire logic [1:0] sel, stb;
	wire logic dat, ck, tx;
	int n_mismatch = 0;
	int n_compared = 0;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	kfp_programmer u_prog (.i_clk(clk), .o_sel(sel), .o_stb(stb),
		.o_dat(dat), .o_ck(ck));
	kfp_prog_port u_dut (.i_clk_sys(clk), .i_sys_rst(rst),
		.i_key_select_input(sel), .i_key_strobe_input(stb),
		.i_key_strobe_data(dat), .i_clock_input_pin(ck), .o_tx(tx));
	task automatic chk(input string nm, input logic e);
		n_compared++;
		if (tx !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, tx);
		end
	endtask
	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// write entry, then all bytes, each committed
	task automatic t_write;
		logic [7:0] b;
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_SV);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_SV);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		chk("write entry", 1'h1);
		for (int i = 0; i < KFP_NUM_BYTES; i++) begin
			b = 8'h3c ^ (8'h1d * 8'(i));
			u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
			for (int k = 0; k < 8; k++) u_prog.pulse(b[k]);
			chk("byte latched", 1'h1);
			u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
			chk("commit", 1'h0);
		end
		u_prog.lvl(KFP_LVL_GND, KFP_LVL_GND);
	endtask
	// read entry, all bytes back msb first across byte borders
	task automatic t_read;
		logic [7:0] b;
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		for (int i = 0; i < KFP_NUM_BYTES; i++) begin
			b = 8'h3c ^ (8'h1d * 8'(i));
			for (int k = 7; k >= 0; k--) begin
				u_prog.pulse(1'h0);
				chk("read bit", b[k]);
			end
		end
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_GND, KFP_LVL_GND);
	endtask
	// entry sequence before init completes is ignored
	task automatic t_early;
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_SV);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_SV);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		chk("early entry", 1'h0);
	endtask
	// write again after a read: a zero byte commits, byte 1 is kept
	task automatic t_rewrite;
		logic [15:0] w;
		w = {8'h00, 8'h3c ^ 8'h1d};
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_SV);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_SV);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		chk("rewrite entry", 1'h1);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		for (int k = 0; k < 8; k++) u_prog.pulse(1'h0);
		chk("zero latched", 1'h1);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		chk("zero commit", 1'h0);
		u_prog.lvl(KFP_LVL_GND, KFP_LVL_GND);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_SV, KFP_LVL_RW);
		for (int k = 15; k >= 0; k--) begin
			u_prog.pulse(1'h1);
			chk("reread bit", w[k]);
		end
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		u_prog.lvl(KFP_LVL_GND, KFP_LVL_GND);
	endtask
	// main sequence
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'h0;
		chk("reset", 1'h0);
		u_prog.lvl(KFP_LVL_RW, KFP_LVL_RW);
		repeat (1499) u_prog.pulse(1'h0);
		t_early;
		u_prog.pulse(1'h0);
		chk("init", 1'h0);
		t_write;
		t_read;
		t_rewrite;
		summarize;
	end
	// watchdog
	initial begin
		repeat (12000) @(posedge clk);
		n_mismatch++;
		summarize;
	end
endmodule // kfp_prog_port_bench
bind kfp_prog_port kfp_prog_port_props u_props (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_key_select_input(i_key_select_input),
	.i_key_strobe_input(i_key_strobe_input),
	.i_key_strobe_data(i_key_strobe_data),
	.i_clock_input_pin(i_clock_input_pin), .o_tx(o_tx));

// ---- testbench/kfp_prog_port_props.sv ----
`timescale 1ns/10ps
module kfp_prog_port_props
	import kfp_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [1:0] i_key_select_input,
	input wire logic [1:0] i_key_strobe_input,
	input wire logic i_key_strobe_data,
	input wire logic i_clock_input_pin,
	input wire logic o_tx
);
	logic [2:0] quiet_r, quiet_nxt;
	logic [10:0] pls_r, pls_nxt;
	logic [4:0] in_q_r;
	wire logic [4:0] in_now = {i_key_select_input, i_key_strobe_input,
		i_clock_input_pin};
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// quiet cycles since key or clock change, init rises at rw level
	always_comb begin
		quiet_nxt = (in_now != in_q_r) ? 3'h0 :
			quiet_r + {2'h0, quiet_r != 3'h7};
		pls_nxt = pls_r + {10'h0, in_now[0] & ~in_q_r[0] &
			in_now[4:1] == 4'h5 & pls_r != 11'h7ff};
	end
	// register helpers
	always_ff @(posedge i_clk_sys) begin
		quiet_r <= i_sys_rst ? 3'h0 : quiet_nxt;
		pls_r <= i_sys_rst ? 11'h000 : pls_nxt;
		in_q_r <= in_now;
	end
	chk_rst_tx_low: assert property ($fell(i_sys_rst) |-> !o_tx)
		else $error("tx high after reset");
	chk_init_tx_low: assert property (pls_r < 11'h5dc |-> !o_tx)
		else $error("tx high before init");
	chk_rise_cause: assert property ($rose(o_tx) |-> quiet_r <= 3'h5)
		else $error("tx rose uncaused");
	chk_fall_cause: assert property ($fell(o_tx) |-> quiet_r <= 3'h5)
		else $error("tx fell uncaused");
	chk_nosv_hold: assert property ((i_key_select_input == KFP_LVL_RW &&
		i_key_strobe_input != KFP_LVL_SV)[*5] |-> $stable(o_tx))
		else $error("tx moved without supervoltage");
	chk_gnd_hold: assert property ((i_key_select_input == KFP_LVL_GND)[*4]
		|=> $stable(o_tx)) else $error("tx moved at ground");
	chk_tx_stands: assert property ($changed(o_tx) |=> $stable(o_tx))
		else $error("tx changed twice");
	chk_quiet_hold: assert property (quiet_r == 3'h7 |-> $stable(o_tx))
		else $error("tx moved when quiet");
endmodule // kfp_prog_port_props

// ---- testbench/kfp_programmer.sv ----
`timescale 1ns/10ps
module kfp_programmer
	import kfp_pkg::*;
(
	input wire logic i_clk,
	output logic [1:0] o_sel,
	output logic [1:0] o_stb,
	output logic o_dat,
	output logic o_ck
);
	// keys grounded, clock low at power-up
	initial begin
		o_sel = KFP_LVL_GND;
		o_stb = KFP_LVL_GND;
		o_dat = 1'h0;
		o_ck = 1'h0;
	end
	// set both key levels and hold them
	task automatic lvl(input logic [1:0] s, input logic [1:0] t);
		@(negedge i_clk);
		o_sel = s;
		o_stb = t;
		repeat (3) @(negedge i_clk);
	endtask
	// one serial clock pulse carrying a data bit, data inverted after
	task automatic pulse(input logic d);
		@(negedge i_clk);
		o_dat = d;
		o_ck = 1'h1;
		repeat (2) @(negedge i_clk);
		o_ck = 1'h0;
		repeat (2) @(negedge i_clk);
		o_dat = ~d;
	endtask
endmodule // kfp_programmer
